// *** hdl/rsc_consts.svh ***
// constants of the reset source controller: offsets, bits, reset values, timing
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define RSC_REG_CAUSE       8'hEF
`define RSC_FLAGS_RESET     7'h02
`define RSC_ENABLES_RESET   3'h2

// ----------------------------------------
// bit positions in the cause register
// ----------------------------------------
`define RSC_BIT_PIN         0
`define RSC_BIT_POR         1
`define RSC_BIT_MCD         2
`define RSC_BIT_WDT         3
`define RSC_BIT_SW          4
`define RSC_BIT_CMP         5
`define RSC_BIT_FLASH       6

// ----------------------------------------
// addresses
// ----------------------------------------
`define RSC_FLASH_TOP       16'h3DFF
`define RSC_RESTART_ADDR    16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define RSC_CLK_PERIOD_NS   50
`define RSC_MCD_TIME_NS     100000
`define RSC_MCD_CYCLES      ((`RSC_MCD_TIME_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_WDT_DIV         12
`define RSC_HOLD_CYCLES     4

`endif

// *** hdl/rsc_pkg.sv ***
// types shared by the reset source controller
package rsc_pkg;
    typedef enum logic [0:0] {
        ST_HOLD,
        ST_RUN
    } rsc_state_t;

    typedef logic [6:0] rsc_cause_t;
    typedef logic [7:0] rsc_byte_t;
    typedef logic [15:0] rsc_addr_t;
endpackage : rsc_pkg

// *** hdl/rsc_mcd_if.sv ***
// carrier between the controller and its clock-loss detector
`timescale 1ns/10ps
interface rsc_mcd_if;
    logic enable;
    logic beat;
    logic timeout;

    modport ctl (output enable, output beat, input timeout);
    modport det (input enable, input beat, output timeout);
endinterface : rsc_mcd_if

// *** hdl/rsc_clock_loss.sv ***
// clock-loss detector: one-shot that times out when the clock heartbeat stops
`timescale 1ns/10ps
`include "rsc_consts.svh"
module rsc_clock_loss #(
    parameter int unsigned MCD_CYCLES = `RSC_MCD_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    rsc_mcd_if.det   mcd
);
    import rsc_pkg::*;

    localparam int unsigned CW = $clog2(MCD_CYCLES + 1);

    logic          s1_q, s1_d;
    logic          s2_q, s2_d;
    logic          s3_q, s3_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          to_q, to_d;

    // ----------------------------------------
    // heartbeat sync and one-shot
    // ----------------------------------------
    always_comb begin
        s1_d  = mcd.beat;
        s2_d  = s1_q;
        s3_d  = s2_q;
        cnt_d = cnt_q;
        to_d  = 1'b0;
        // any heartbeat edge retriggers the one-shot
        if (!mcd.enable || (s2_q != s3_q)) begin
            cnt_d = '0;
        end else if (cnt_q < CW'(MCD_CYCLES)) begin
            cnt_d = cnt_q + CW'(1);
        end else begin
            to_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            cnt_q <= '0;
            to_q  <= 1'b0;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            cnt_q <= cnt_d;
            to_q  <= to_d;
        end
    end

    assign mcd.timeout = to_q;
endmodule : rsc_clock_loss

// *** hdl/rsc_reset_source_controller.sv ***
// reset source controller: gathers reset sources, holds reset, records cause
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "rsc_consts.svh"
// What this block does
// - low on reset pin resets device; pin flag bit 0 reads one afterwards
// - enabled clock-loss detector resets when clock stalls beyond 100 us
// - bit 2 reads clock-loss cause; writing it enables or disables detector
// - resets other than power and supply leave the reset pin undriven
// - after bit 5 write, comparator low output (pos below neg) resets device
// - bit 5 reads one only when comparator caused the last reset
// - after any reset watchdog runs, clocked by system clock over 12
// - flash-enabled xdata write above 0x3DFF resets device
// - code read above 0x3DFF resets device
// - branch or fetch above 0x3DFF resets device
// - flash access refused by security resets device
// - bit 6 reads one after flash-error reset; read only
// - writing one to bit 4 forces reset; bit 4 reads one afterwards
// - writing one to bit 1 selects the supply monitor as reset source
// - bit 1 reads one after power-on or supply reset; others undefined then
// - every reset other than power-on or supply clears the power-on flag
// - leaving reset restarts execution at address 0x0000
module rsc_reset_source_controller #(
    parameter int unsigned HOLD_CYCLES = `RSC_HOLD_CYCLES,
    parameter int unsigned MCD_CYCLES  = `RSC_MCD_CYCLES
) (
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire rsc_pkg::rsc_byte_t reg_addr,
    input  wire rsc_pkg::rsc_byte_t reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output rsc_pkg::rsc_byte_t reg_rdata,
    input  wire logic         rst_pin_in,
    output logic              rst_pin_out,
    output logic              rst_pin_oe_n,
    input  wire logic         system_clock_beat,
    input  wire logic         comparator_out,
    input  wire logic         supply_ok,
    input  wire logic         watchdog_overflow,
    input  wire logic         watchdog_disable,
    input  wire logic         flash_write_enable,
    input  wire logic         xdata_move_instr,
    input  wire rsc_pkg::rsc_addr_t xdata_addr,
    input  wire logic         code_read_instr,
    input  wire rsc_pkg::rsc_addr_t code_addr,
    input  wire logic         fetch_valid,
    input  wire rsc_pkg::rsc_addr_t fetch_addr,
    input  wire logic         flash_refused,
    output logic              sys_reset_n,
    output logic              pc_restart,
    output rsc_pkg::rsc_addr_t restart_addr,
    output logic              watchdog_function_en,
    output logic              watchdog_tick
);
    import rsc_pkg::*;

    localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
    localparam logic [2:0]  EN_RST = `RSC_ENABLES_RESET; // clock loss, supply select, comparator

    rsc_mcd_if mcd ();

    rsc_clock_loss #(
        .MCD_CYCLES (MCD_CYCLES)
    ) u_clock_loss (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .mcd      (mcd)
    );

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // pin, comparator and supply level come from outside the clock domain
    logic [2:0] sa_q, sa_d;
    logic [2:0] sb_q, sb_d;
    logic       pin_s, cmp_s, vdd_s;

    always_comb begin
        sa_d = {supply_ok, comparator_out, rst_pin_in};
        sb_d = sa_q;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sa_q <= 3'h7;
            sb_q <= 3'h7;
        end else begin
            sa_q <= sa_d;
            sb_q <= sb_d;
        end
    end

    assign pin_s = sb_q[0];
    assign cmp_s = sb_q[1];
    assign vdd_s = sb_q[2];

    // ----------------------------------------
    // reset sources
    // ----------------------------------------
    rsc_state_t    st_q, st_d;
    rsc_cause_t    pend_q, pend_d;
    rsc_cause_t    flags_q, flags_d;
    logic [HW-1:0] hold_q, hold_d;
    logic          mcd_en_q, mcd_en_d;
    logic          cmp_en_q, cmp_en_d;
    logic          vdd_sel_q, vdd_sel_d;
    logic          srst_n_q, srst_n_d;
    logic          oe_n_q, oe_n_d;
    logic          restart_q, restart_d;
    logic          wdt_run_q, wdt_run_d;
    logic [1:0]    own_q, own_d; // own pin drive, seen two syncs late, must not self-trigger
    logic [3:0]    wdt_div_q, wdt_div_d;
    logic          wdt_tick_q, wdt_tick_d;
    rsc_cause_t    src;
    logic          sel_wr;
    logic          flash_fault;

    assign sel_wr = reg_wr && (reg_addr == `RSC_REG_CAUSE);

    always_comb begin
        flash_fault = 1'b0;
        if (flash_write_enable && xdata_move_instr && (xdata_addr > `RSC_FLASH_TOP)) begin
            flash_fault = 1'b1;
        end
        if (code_read_instr && (code_addr > `RSC_FLASH_TOP)) begin
            flash_fault = 1'b1;
        end
        if (fetch_valid && (fetch_addr > `RSC_FLASH_TOP)) begin
            flash_fault = 1'b1;
        end
        if (flash_refused) begin
            flash_fault = 1'b1;
        end
    end

    always_comb begin
        src = '0;
        src[`RSC_BIT_PIN]   = !pin_s && (own_q == 2'h0);
        src[`RSC_BIT_POR]   = vdd_sel_q && !vdd_s;
        src[`RSC_BIT_MCD]   = mcd.timeout;
        src[`RSC_BIT_WDT]   = watchdog_overflow;
        src[`RSC_BIT_SW]    = (st_q == ST_RUN) && sel_wr && reg_wdata[`RSC_BIT_SW];
        src[`RSC_BIT_CMP]   = cmp_en_q && !cmp_s;
        src[`RSC_BIT_FLASH] = flash_fault;
    end

    // ----------------------------------------
    // sequencer and control bits
    // ----------------------------------------
    always_comb begin
        st_d      = st_q;
        pend_d    = pend_q;
        flags_d   = flags_q;
        hold_d    = hold_q;
        mcd_en_d  = mcd_en_q;
        cmp_en_d  = cmp_en_q;
        vdd_sel_d = vdd_sel_q;
        restart_d = 1'b0;
        wdt_run_d = wdt_run_q;
        own_d     = {own_q[0], !oe_n_q};
        case (st_q)
            ST_RUN: begin
                if (|src) begin
                    // reset is the OR of all enabled sources
                    st_d     = ST_HOLD;
                    pend_d   = src;
                    hold_d   = HW'(HOLD_CYCLES);
                    mcd_en_d = 1'b0;
                    cmp_en_d = 1'b0;
                end else if (sel_wr) begin
                    mcd_en_d  = reg_wdata[`RSC_BIT_MCD];
                    cmp_en_d  = reg_wdata[`RSC_BIT_CMP];
                    vdd_sel_d = reg_wdata[`RSC_BIT_POR];
                end
                if (watchdog_disable) begin
                    wdt_run_d = 1'b0;
                end
            end
            ST_HOLD: begin
                pend_d = pend_q | src;
                if (hold_q != '0) begin
                    hold_d = hold_q - HW'(1);
                end else if (src == '0) begin
                    // flags are replaced, so power-on flag drops on other causes
                    flags_d   = pend_q;
                    pend_d    = '0;
                    st_d      = ST_RUN;
                    restart_d = 1'b1;
                    wdt_run_d = 1'b1;
                end
            end
            default: begin
                st_d = ST_HOLD;
            end
        endcase
        srst_n_d = (st_d == ST_RUN);
        // only power-on and supply faults pull the pin, let go once hold ends with supply good
        oe_n_d   = !((st_d == ST_HOLD) && pend_d[`RSC_BIT_POR] &&
                     ((hold_d != '0) || !vdd_s));
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q      <= ST_HOLD;
            pend_q    <= `RSC_FLAGS_RESET;
            flags_q   <= `RSC_FLAGS_RESET;
            hold_q    <= HW'(HOLD_CYCLES);
            mcd_en_q  <= EN_RST[0];
            cmp_en_q  <= EN_RST[2];
            vdd_sel_q <= EN_RST[1];
            srst_n_q  <= 1'b0;
            oe_n_q    <= 1'b0;
            restart_q <= 1'b0;
            wdt_run_q <= 1'b0;
            own_q     <= 2'h3;
        end else begin
            st_q      <= st_d;
            pend_q    <= pend_d;
            flags_q   <= flags_d;
            hold_q    <= hold_d;
            mcd_en_q  <= mcd_en_d;
            cmp_en_q  <= cmp_en_d;
            vdd_sel_q <= vdd_sel_d;
            srst_n_q  <= srst_n_d;
            oe_n_q    <= oe_n_d;
            restart_q <= restart_d;
            wdt_run_q <= wdt_run_d;
            own_q     <= own_d;
        end
    end

    assign mcd.enable = mcd_en_q;
    assign mcd.beat   = system_clock_beat;

    // ----------------------------------------
    // watchdog clock divider
    // ----------------------------------------
    always_comb begin
        wdt_div_d  = '0;
        wdt_tick_d = 1'b0;
        if ((st_q == ST_RUN) && wdt_run_q) begin
            if (wdt_div_q == 4'(`RSC_WDT_DIV - 1)) begin
                wdt_tick_d = 1'b1;
            end else begin
                wdt_div_d = wdt_div_q + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdt_div_q  <= 4'h0;
            wdt_tick_q <= 1'b0;
        end else begin
            wdt_div_q  <= wdt_div_d;
            wdt_tick_q <= wdt_tick_d;
        end
    end

    // ----------------------------------------
    // register readback
    // ----------------------------------------
    rsc_byte_t rdata_q, rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd && (reg_addr == `RSC_REG_CAUSE)) begin
            // unused bit 7 reads zero; writes to flag-only bits are dropped
            rdata_d = {1'b0, flags_q};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata            = rdata_q;
    assign rst_pin_out          = 1'b0;
    assign rst_pin_oe_n         = oe_n_q;
    assign sys_reset_n          = srst_n_q;
    assign pc_restart           = restart_q;
    assign restart_addr         = `RSC_RESTART_ADDR;
    assign watchdog_function_en = wdt_run_q;
    assign watchdog_tick        = wdt_tick_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_release;
        (st_q == ST_HOLD) && (st_d == ST_RUN);
    endsequence

    sequence s_tick_gap;
        !wdt_tick_q [*8] ##1 !wdt_tick_q [*3];
    endsequence

    a_pin_holds_reset: assert property (
        (st_q == ST_RUN) && src[`RSC_BIT_PIN] |=> !sys_reset_n && pend_q[`RSC_BIT_PIN])
        else $error("pin low did not enter reset");
    a_release_flags: assert property (
        s_release |=> pc_restart && sys_reset_n && (flags_q == $past(pend_q)))
        else $error("cause flags not latched on release");
    a_clock_loss_reset: assert property (
        (st_q == ST_RUN) && mcd.timeout |=> !sys_reset_n && pend_q[`RSC_BIT_MCD])
        else $error("clock loss did not reset");
    a_cmp_reset_low: assert property (
        (st_q == ST_RUN) && cmp_en_q && !cmp_s |=> pend_q[`RSC_BIT_CMP] && !sys_reset_n)
        else $error("comparator low did not reset");
    a_pin_left_alone: assert property (
        (st_q == ST_HOLD) && !pend_q[`RSC_BIT_POR] |-> rst_pin_oe_n)
        else $error("reset pin driven for internal reset");
    a_wdt_div_twelve: assert property (
        wdt_tick_q |=> s_tick_gap)
        else $error("watchdog tick spacing below twelve");
    a_wdt_cause_bit: assert property (
        (st_q == ST_RUN) && watchdog_overflow |=> pend_q[`RSC_BIT_WDT] && (st_q == ST_HOLD))
        else $error("watchdog overflow not recorded");
    a_flash_cause_bit: assert property (
        (st_q == ST_RUN) && flash_fault |=> pend_q[`RSC_BIT_FLASH] && !sys_reset_n)
        else $error("flash fault not recorded");
    a_soft_reset_bit: assert property (
        (st_q == ST_RUN) && sel_wr && reg_wdata[`RSC_BIT_SW] |=> pend_q[`RSC_BIT_SW] ##1 !sys_reset_n)
        else $error("software reset not forced");
    a_restart_after_hold: assert property (
        pc_restart |-> $past(st_q) == ST_HOLD && restart_addr == 16'h0000)
        else $error("restart outside reset exit");
endmodule : rsc_reset_source_controller

// *** verif/rsc_pin_partner.sv ***
// partner model: external reset circuitry on the open-drain reset pin
`timescale 1ns/10ps
module rsc_pin_partner (
    input  wire logic core_clk,
    input  wire logic dev_out,
    input  wire logic dev_oe_n,
    output logic      pin
);
    logic press_q;
    // pull-up wins when nobody pulls low, so a released pin never keeps a stale level
    assign pin = (press_q || (!dev_oe_n && !dev_out)) ? 1'b0 : 1'b1;
    initial press_q = 1'b0;
    task automatic press(input int cycles);
        @(posedge core_clk);
        press_q <= 1'b1;
        repeat (cycles) @(posedge core_clk);
        press_q <= 1'b0;
    endtask : press
endmodule : rsc_pin_partner

// *** verif/tb_top.sv ***
// self-checking testbench for the reset source controller
`timescale 1ns/10ps
`include "rsc_consts.svh"
module tb_top;
    import rsc_pkg::*;
    localparam int MCD_CYC = 20;
    logic      core_clk, reset_n, reg_wr, reg_rd, rst_pin_in, beat_run, beat;
    rsc_byte_t reg_addr, reg_wdata, reg_rdata, rd;
    logic      rst_pin_out, rst_pin_oe_n, comparator_out, supply_ok, fl_we;
    logic      wdt_ovf, wdt_dis, xmov, cread, fvalid, frefused;
    rsc_addr_t xaddr, caddr, faddr, restart_addr;
    logic      sys_reset_n, pc_restart, wdt_en, wdt_tick;
    int        n_fail, cmp_count, k;

    rsc_reset_source_controller #(.MCD_CYCLES(MCD_CYC)) u_rsc_reset_source_controller (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .system_clock_beat(beat), .comparator_out(comparator_out), .supply_ok(supply_ok),
        .watchdog_overflow(wdt_ovf), .watchdog_disable(wdt_dis),
        .flash_write_enable(fl_we), .xdata_move_instr(xmov), .xdata_addr(xaddr),
        .code_read_instr(cread), .code_addr(caddr), .fetch_valid(fvalid),
        .fetch_addr(faddr), .flash_refused(frefused), .sys_reset_n(sys_reset_n),
        .pc_restart(pc_restart), .restart_addr(restart_addr),
        .watchdog_function_en(wdt_en), .watchdog_tick(wdt_tick));

    rsc_pin_partner u_rsc_pin_partner (
        .core_clk(core_clk), .dev_out(rst_pin_out), .dev_oe_n(rst_pin_oe_n),
        .pin(rst_pin_in));

    always #25 core_clk = ~core_clk;
    // heartbeat stands for the system clock; stopping it is the clock-loss case
    always @(posedge core_clk) if (beat_run) beat <= ~beat;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check8(input rsc_byte_t got, input rsc_byte_t exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8

    task automatic check1(input logic got, input logic exp);
        check8({7'h00, got}, {7'h00, exp});
    endtask : check1

    // constant writes only, never a read value written back
    task automatic reg_write(input rsc_byte_t a, input rsc_byte_t d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input rsc_byte_t a, output rsc_byte_t d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // mask order: xdata write, code read, fetch, refused, watchdog overflow
    task automatic pulse(input logic [4:0] m, input rsc_addr_t a);
        @(posedge core_clk);
        {xaddr, caddr, faddr} <= {a, a, a};
        {xmov, cread, fvalid, frefused, wdt_ovf} <= m;
        @(posedge core_clk);
        {xmov, cread, fvalid, frefused, wdt_ovf} <= 5'h00;
    endtask : pulse

    task automatic quiet(input int n);
        repeat (n) @(negedge core_clk);
        check1(sys_reset_n, 1'b1);
    endtask : quiet

    task automatic wait_reset(input rsc_byte_t exp, input logic pin_low);
        int   i;
        logic saw;
        saw = 1'b0;
        for (i = 0; i < 200; i++) begin
            @(negedge core_clk);
            if (sys_reset_n === 1'b0) break;
        end
        check1(sys_reset_n, 1'b0);
        for (i = 0; i < 400 && sys_reset_n !== 1'b1; i++) begin
            if (rst_pin_oe_n === 1'b0) saw = 1'b1;
            @(negedge core_clk);
        end
        check1(sys_reset_n, 1'b1);
        check1(pc_restart, 1'b1);
        check8(restart_addr[15:8] | restart_addr[7:0], 8'h00);
        check1(saw, pin_low);
        check1(rst_pin_out, 1'b0);
        check1(wdt_en, 1'b1);
        reg_read(`RSC_REG_CAUSE, rd);
        check8(rd, exp);
    endtask : wait_reset

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_on();
        int n;
        wait_reset(8'h02, 1'b1);
        reg_read(8'h00, rd);
        check8(rd, 8'h00);
        for (n = 0; n < 30 && wdt_tick !== 1'b1; n++) @(negedge core_clk);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (wdt_tick !== 1'b1 && n < 30);
        check8(n[7:0], 8'h0C);
        @(posedge core_clk);
        wdt_dis <= 1'b1;
        @(posedge core_clk);
        wdt_dis <= 1'b0;
        @(negedge core_clk);
        check1(wdt_en, 1'b0);
    endtask : t_power_on

    task automatic t_soft_and_pin();
        reg_write(`RSC_REG_CAUSE, 8'h10);
        wait_reset(8'h10, 1'b0);
        u_rsc_pin_partner.press(10);
        wait_reset(8'h01, 1'b0);
    endtask : t_soft_and_pin

    task automatic t_comparator();
        comparator_out <= 1'b0;
        quiet(8);
        comparator_out <= 1'b1;
        // let the comparator settle before it may reset the device
        quiet(6);
        reg_write(`RSC_REG_CAUSE, 8'h20);
        quiet(6);
        comparator_out <= 1'b0;
        repeat (6) @(posedge core_clk);
        comparator_out <= 1'b1;
        wait_reset(8'h20, 1'b0);
    endtask : t_comparator

    task automatic t_clock_loss();
        reg_write(`RSC_REG_CAUSE, 8'h00);
        beat_run <= 1'b0;
        quiet(3 * MCD_CYC);
        beat_run <= 1'b1;
        reg_write(`RSC_REG_CAUSE, 8'h04);
        quiet(3 * MCD_CYC);
        beat_run <= 1'b0;
        wait_reset(8'h04, 1'b0);
        beat_run <= 1'b1;
    endtask : t_clock_loss

    task automatic t_flash_wdt();
        reg_write(`RSC_REG_CAUSE, 8'h48);
        quiet(8);
        fl_we <= 1'b1;
        for (k = 0; k < 3; k++) begin
            pulse(5'h10 >> k, 16'h3DFF);
            quiet(6);
            pulse(5'h10 >> k, 16'h3E00);
            wait_reset(8'h40, 1'b0);
        end
        pulse(5'h02, 16'h0000);
        wait_reset(8'h40, 1'b0);
        fl_we <= 1'b0;
        pulse(5'h10, 16'h3E00);
        quiet(6);
        pulse(5'h01, 16'h0000);
        wait_reset(8'h08, 1'b0);
        pulse(5'h03, 16'h0000);
        wait_reset(8'h48, 1'b0);
    endtask : t_flash_wdt

    task automatic t_supply();
        // earlier scenarios deselected the supply monitor; select it again first
        reg_write(`RSC_REG_CAUSE, 8'h02);
        quiet(4);
        @(posedge core_clk);
        supply_ok <= 1'b0;
        repeat (10) @(posedge core_clk);
        supply_ok <= 1'b1;
        wait_reset(8'h02, 1'b1);
    endtask : t_supply

    task automatic test_done();
        $display("compares %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        {core_clk, reset_n, reg_wr, reg_rd, beat, wdt_ovf, wdt_dis, fl_we} = '0;
        {xmov, cread, fvalid, frefused, n_fail, cmp_count} = '0;
        {reg_addr, reg_wdata, xaddr, caddr, faddr} = '0;
        {beat_run, comparator_out, supply_ok} = 3'h7;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        t_power_on();
        t_soft_and_pin();
        t_comparator();
        t_clock_loss();
        t_flash_wdt();
        t_supply();
        test_done();
    end

    // generous bound: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        test_done();
    end
endmodule : tb_top
